// File: include/sfw_pkg.sv
// Function
// - Workspace is sixteen 16-bit words starting at the workspace pointer.
// - Only registers one to fifteen add an index bias to an address.
// - Shifts may take their bit count from workspace register zero.
// - Link return address and trap parameter go to register eleven.
// - Serial I/O base bit address comes from register twelve bits 3-14.
// - Context return reloads pointer, counter, status from registers 13-15.
// - Status word low four bits hold the interrupt mask.
// - Unsigned-greater compares unsigned; MSB weight 32768 word, 128 byte.
// - Unsigned-greater on compare: src MSB 1, dst 0, or equal MSBs, difference MSB.
// - Signed-greater compares two's complement with MSB as sign.
// - Signed-greater on compare: src MSB 0, dst 1, or equal MSBs, difference MSB.
// - Equal flag set when compared operands match, else cleared.
// - Arithmetic carry is the carry out of the sign bit.
// - Shift carry holds the last bit shifted out.
// - Add overflow: operand MSBs equal and result MSB differs from destination.
// - Subtract overflow: operand MSBs differ and result MSB differs from destination.
// - Divide overflow when dividend upper half is at least the divisor.
// - Arithmetic left shift overflow when the MSB changes during the shift.
// - Absolute and negate overflow when source is 8000 hex.
// - Byte operations set odd parity when the result has odd ones; byte compare takes parity of the source byte.
// - Extended-operation flag set when a software trap starts.
// - Status bits an instruction does not affect keep their value.
// - Bits 7-9 stored and driven out; bit 11 not driven out.
// - Context switch saves status to register 15, then clears bits 7-11.
// - Maskable interrupt loads mask with level minus one; load interrupt does not.
// - Reset interrupt clears the whole status word.
package sfw_pkg;

  // ****************************************
  // Status word bit positions (LSB numbering)
  // ****************************************
  localparam int STB_LGT   = 15;
  localparam int STB_AGT   = 14;
  localparam int STB_EQ    = 13;
  localparam int STB_C     = 12;
  localparam int STB_OV    = 11;
  localparam int STB_OP    = 10;
  localparam int STB_X     = 9;
  localparam int STB_EXT_LO = 6;
  localparam int STB_EXT_HI = 8;
  localparam int STB_MASK_HI = 3;

  localparam logic [15:0] ST_RESET      = 16'h0000;
  localparam logic [15:0] CTX_CLEAR     = 16'h01F0;
  localparam logic [15:0] MASK_FIELD    = 16'h000F;
  localparam logic [15:0] MAX_NEG       = 16'h8000;
  localparam logic [15:0] WP_RESET      = 16'h0000;

  // ****************************************
  // Workspace register roles
  // ****************************************
  localparam int WS_REGS = 16;
  localparam logic [3:0] R_COUNT  = 4'h0;
  localparam logic [3:0] R_LINK   = 4'hB;
  localparam logic [3:0] R_OLD_WP = 4'hD;
  localparam logic [3:0] R_OLD_PC = 4'hE;
  localparam logic [3:0] R_OLD_ST = 4'hF;
  localparam int IO_BASE_LO = 1;
  localparam int IO_BASE_HI = 12;

  typedef enum logic [4:0] {
    SFW_OP_NOP, SFW_OP_ADD, SFW_OP_SUB, SFW_OP_CMP, SFW_OP_MOVE,
    SFW_OP_SLA, SFW_OP_SRA, SFW_OP_SRL, SFW_OP_SRC, SFW_OP_DIV,
    SFW_OP_ABS, SFW_OP_NEG, SFW_OP_LOAD_ST, SFW_OP_LOAD_MASK,
    SFW_OP_LOAD_WP, SFW_OP_BL, SFW_OP_XOP, SFW_OP_INTR,
    SFW_OP_CTX_RET, SFW_OP_RESET_INT
  } sfw_op_type;

  typedef struct packed {
    sfw_op_type  op;
    logic        is_byte;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] r0;
    logic [15:0] aux;
    logic [3:0]  count;
    logic [3:0]  level;
    logic        load_int;
  } sfw_cmd_type;

  typedef struct packed {
    logic [15:0] value;
    logic [15:0] affect;
    logic [15:0] result;
  } sfw_flag_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sfw_mem_req_type;

  function automatic logic [15:0] ws_addr(input logic [15:0] wp, input logic [3:0] n);
    ws_addr = wp + {11'h000, n, 1'b0};
  endfunction

endpackage

// File: hdl/sfw_flag_calc.sv
`timescale 1ns/1ps
module sfw_flag_calc (
  input  sfw_pkg::sfw_cmd_type  cmd,
  output sfw_pkg::sfw_flag_type flags
);

  logic [15:0] s;
  logic [15:0] d;
  logic [15:0] res;
  logic [15:0] val;
  logic [15:0] aff;
  logic [16:0] sum;
  logic [16:0] dif;
  logic [16:0] neg;
  logic [4:0]  cnt;
  logic        zc;
  logic        sc;
  logic        so;

  // Byte operands sit in the left byte so bit 15 is always the MSB
  always_comb begin
    s = cmd.is_byte ? {cmd.src[15:8], 8'h00} : cmd.src;
    d = cmd.is_byte ? {cmd.dst[15:8], 8'h00} : cmd.dst;
    sum = {1'b0, d} + {1'b0, s};
    dif = {1'b0, d} + {1'b0, ~s} + 17'h00001;
    neg = {1'b0, ~s} + 17'h00001;
    if (cmd.count != 4'h0) begin
      cnt = {1'b0, cmd.count};
    end else if (cmd.r0[3:0] != 4'h0) begin
      cnt = {1'b0, cmd.r0[3:0]};
    end else begin
      cnt = 5'h10;
    end
    res = d;
    val = 16'h0000;
    aff = 16'h0000;
    zc = 1'b0;
    sc = 1'b0;
    so = 1'b0;
    unique case (cmd.op)
      sfw_pkg::SFW_OP_ADD: begin
        res = sum[15:0];
        zc = 1'b1;
        val[sfw_pkg::STB_C] = sum[16];
        val[sfw_pkg::STB_OV] = (s[15] == d[15]) && (res[15] != d[15]);
        aff[sfw_pkg::STB_C] = 1'b1;
        aff[sfw_pkg::STB_OV] = 1'b1;
      end
      sfw_pkg::SFW_OP_SUB: begin
        res = dif[15:0];
        zc = 1'b1;
        val[sfw_pkg::STB_C] = dif[16];
        val[sfw_pkg::STB_OV] = (s[15] != d[15]) && (res[15] != d[15]);
        aff[sfw_pkg::STB_C] = 1'b1;
        aff[sfw_pkg::STB_OV] = 1'b1;
      end
      sfw_pkg::SFW_OP_CMP: begin
        val[sfw_pkg::STB_LGT] = (s[15] && !d[15]) || ((s[15] == d[15]) && dif[15]);
        val[sfw_pkg::STB_AGT] = (!s[15] && d[15]) || ((s[15] == d[15]) && dif[15]);
        val[sfw_pkg::STB_EQ] = (s == d);
        aff[sfw_pkg::STB_LGT] = 1'b1;
        aff[sfw_pkg::STB_AGT] = 1'b1;
        aff[sfw_pkg::STB_EQ] = 1'b1;
      end
      sfw_pkg::SFW_OP_MOVE: begin
        res = s;
        zc = 1'b1;
      end
      sfw_pkg::SFW_OP_SLA, sfw_pkg::SFW_OP_SRA,
      sfw_pkg::SFW_OP_SRL, sfw_pkg::SFW_OP_SRC: begin
        res = cmd.dst;
        for (int i = 0; i < 16; i++) begin
          if (5'(i) < cnt) begin
            unique case (cmd.op)
              sfw_pkg::SFW_OP_SLA: begin
                sc = res[15];
                res = {res[14:0], 1'b0};
                so = so | (res[15] != cmd.dst[15]);
              end
              sfw_pkg::SFW_OP_SRA: begin
                sc = res[0];
                res = {res[15], res[15:1]};
              end
              sfw_pkg::SFW_OP_SRL: begin
                sc = res[0];
                res = {1'b0, res[15:1]};
              end
              default: begin
                sc = res[0];
                res = {res[0], res[15:1]};
              end
            endcase
          end
        end
        zc = 1'b1;
        val[sfw_pkg::STB_C] = sc;
        aff[sfw_pkg::STB_C] = 1'b1;
        val[sfw_pkg::STB_OV] = so;
        aff[sfw_pkg::STB_OV] = (cmd.op == sfw_pkg::SFW_OP_SLA);
      end
      sfw_pkg::SFW_OP_DIV: begin
        val[sfw_pkg::STB_OV] = (cmd.dst >= cmd.src);
        aff[sfw_pkg::STB_OV] = 1'b1;
      end
      sfw_pkg::SFW_OP_ABS, sfw_pkg::SFW_OP_NEG: begin
        if (cmd.op == sfw_pkg::SFW_OP_NEG || cmd.src[15]) begin
          res = neg[15:0];
          val[sfw_pkg::STB_C] = neg[16];
        end else begin
          res = cmd.src;
        end
        zc = 1'b1;
        val[sfw_pkg::STB_OV] = (cmd.src == sfw_pkg::MAX_NEG);
        aff[sfw_pkg::STB_C] = 1'b1;
        aff[sfw_pkg::STB_OV] = 1'b1;
      end
      default: begin
        res = d;
      end
    endcase
    if (zc) begin
      val[sfw_pkg::STB_LGT] = (res != 16'h0000);
      val[sfw_pkg::STB_AGT] = !res[15] && (res != 16'h0000);
      val[sfw_pkg::STB_EQ] = (res == 16'h0000);
      aff[sfw_pkg::STB_LGT] = 1'b1;
      aff[sfw_pkg::STB_AGT] = 1'b1;
      aff[sfw_pkg::STB_EQ] = 1'b1;
    end
    if (cmd.is_byte && (zc || cmd.op == sfw_pkg::SFW_OP_CMP)) begin
      val[sfw_pkg::STB_OP] = ^((cmd.op == sfw_pkg::SFW_OP_CMP) ? s[15:8] : res[15:8]);
      aff[sfw_pkg::STB_OP] = 1'b1;
    end
    flags.value = val;
    flags.affect = aff;
    flags.result = res;
  end

endmodule

// File: hdl/sfw_status_unit.sv
`timescale 1ns/1ps
module sfw_status_unit (
  input  logic                     sys_clk,
  input  logic                     reset,
  input  sfw_pkg::sfw_cmd_type     cmd,
  input  logic                     cmd_valid,
  output logic                     cmd_ready,
  output sfw_pkg::sfw_mem_req_type mem,
  input  logic [15:0]              mem_rdata,
  input  logic                     mem_rvalid,
  output logic [15:0]              status_word,
  output logic [2:0]               ext_status_bits,
  output logic [15:0]              workspace_ptr,
  output logic [15:0]              result_word,
  output logic                     pc_load,
  output logic [15:0]              pc_value,
  input  logic                     idx_req,
  input  logic [3:0]               idx_sel,
  input  logic [15:0]              idx_base,
  input  logic [15:0]              idx_value,
  output logic [15:0]              idx_addr,
  output logic                     idx_done,
  input  logic [15:0]              r12_value,
  output logic [11:0]              io_bit_base
);

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    SFW_IDLE, SFW_SAVE_WP, SFW_SAVE_PC, SFW_SAVE_ST, SFW_SAVE_LINK,
    SFW_RET_WP, SFW_RET_PC, SFW_RET_ST
  } sfw_state_type;

  sfw_state_type            state;
  sfw_state_type            next_state;
  logic [15:0]              st;
  logic [15:0]              next_st;
  logic [15:0]              wp;
  logic [15:0]              next_wp;
  logic [15:0]              hold_wp;
  logic [15:0]              next_hold_wp;
  logic [15:0]              hold_pc;
  logic [15:0]              next_hold_pc;
  logic [15:0]              hold_st;
  logic [15:0]              next_hold_st;
  logic [15:0]              hold_link;
  logic [15:0]              next_hold_link;
  logic                     hold_xop;
  logic                     next_hold_xop;
  sfw_pkg::sfw_mem_req_type next_mem;
  logic [15:0]              next_result;
  logic                     next_pc_load;
  logic [15:0]              next_pc_value;
  logic [15:0]              next_idx_addr;
  logic                     next_idx_done;
  logic [11:0]              next_io_base;
  sfw_pkg::sfw_flag_type    flags;
  logic                     take;

  sfw_flag_calc u_flags (
    .cmd   (cmd),
    .flags (flags)
  );

  assign cmd_ready = (state == SFW_IDLE);
  assign take = cmd_valid && cmd_ready;
  assign status_word = st;
  assign workspace_ptr = wp;
  // Bit 11 stays inside; only bits 7-9 go to the connector
  assign ext_status_bits = st[sfw_pkg::STB_EXT_HI:sfw_pkg::STB_EXT_LO];

  // ****************************************
  // Status word, pointer and sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_st = st;
    next_wp = wp;
    next_hold_wp = hold_wp;
    next_hold_pc = hold_pc;
    next_hold_st = hold_st;
    next_hold_link = hold_link;
    next_hold_xop = hold_xop;
    next_result = result_word;
    next_pc_load = 1'b0;
    next_pc_value = pc_value;
    if (take) begin
      unique case (cmd.op)
        sfw_pkg::SFW_OP_LOAD_ST: begin
          next_st = cmd.src;
        end
        sfw_pkg::SFW_OP_LOAD_MASK: begin
          next_st = (st & ~sfw_pkg::MASK_FIELD) | (cmd.src & sfw_pkg::MASK_FIELD);
        end
        sfw_pkg::SFW_OP_LOAD_WP: begin
          next_wp = cmd.aux;
        end
        sfw_pkg::SFW_OP_RESET_INT: begin
          next_st = sfw_pkg::ST_RESET;
        end
        sfw_pkg::SFW_OP_BL: begin
          next_hold_link = cmd.aux;
          next_state = SFW_SAVE_LINK;
        end
        sfw_pkg::SFW_OP_XOP, sfw_pkg::SFW_OP_INTR: begin
          // Old context is latched before the new pointer takes effect
          next_hold_wp = wp;
          next_hold_pc = cmd.dst;
          next_hold_st = st;
          next_hold_link = cmd.src;
          next_hold_xop = (cmd.op == sfw_pkg::SFW_OP_XOP);
          next_wp = cmd.aux;
          next_st = st & ~sfw_pkg::CTX_CLEAR;
          if (cmd.op == sfw_pkg::SFW_OP_XOP) begin
            next_st[sfw_pkg::STB_X] = 1'b1;
          end else if (!cmd.load_int && cmd.level != 4'h0) begin
            next_st[sfw_pkg::STB_MASK_HI:0] = cmd.level - 4'h1;
          end
          next_state = SFW_SAVE_WP;
        end
        sfw_pkg::SFW_OP_CTX_RET: begin
          next_state = SFW_RET_WP;
        end
        default: begin
          // Merge only the bits this operation affects
          next_st = (st & ~flags.affect) | (flags.value & flags.affect);
          next_result = flags.result;
        end
      endcase
    end else begin
      unique case (state)
        SFW_IDLE, SFW_SAVE_LINK: begin
          next_state = SFW_IDLE;
        end
        SFW_SAVE_WP: begin
          next_state = SFW_SAVE_PC;
        end
        SFW_SAVE_PC: begin
          next_state = SFW_SAVE_ST;
        end
        SFW_SAVE_ST: begin
          next_state = hold_xop ? SFW_SAVE_LINK : SFW_IDLE;
        end
        SFW_RET_WP: begin
          if (mem_rvalid) begin
            next_hold_wp = mem_rdata;
            next_state = SFW_RET_PC;
          end
        end
        SFW_RET_PC: begin
          if (mem_rvalid) begin
            next_hold_pc = mem_rdata;
            next_state = SFW_RET_ST;
          end
        end
        SFW_RET_ST: begin
          if (mem_rvalid) begin
            // Pointer switches last so all three reads use the old frame
            next_st = mem_rdata;
            next_wp = hold_wp;
            next_pc_value = hold_pc;
            next_pc_load = 1'b1;
            next_state = SFW_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Workspace memory request
  // ****************************************
  always_comb begin
    next_mem.req = 1'b1;
    next_mem.we = 1'b1;
    next_mem.wdata = 16'h0000;
    next_mem.addr = 16'h0000;
    unique case (next_state)
      SFW_IDLE: begin
        next_mem.req = 1'b0;
        next_mem.we = 1'b0;
      end
      SFW_SAVE_WP: begin
        next_mem.addr = sfw_pkg::ws_addr(next_wp, sfw_pkg::R_OLD_WP);
        next_mem.wdata = next_hold_wp;
      end
      SFW_SAVE_PC: begin
        next_mem.addr = sfw_pkg::ws_addr(next_wp, sfw_pkg::R_OLD_PC);
        next_mem.wdata = next_hold_pc;
      end
      SFW_SAVE_ST: begin
        next_mem.addr = sfw_pkg::ws_addr(next_wp, sfw_pkg::R_OLD_ST);
        next_mem.wdata = next_hold_st;
      end
      SFW_SAVE_LINK: begin
        next_mem.addr = sfw_pkg::ws_addr(next_wp, sfw_pkg::R_LINK);
        next_mem.wdata = next_hold_link;
      end
      SFW_RET_WP: begin
        next_mem.we = 1'b0;
        next_mem.addr = sfw_pkg::ws_addr(next_wp, sfw_pkg::R_OLD_WP);
      end
      SFW_RET_PC: begin
        next_mem.we = 1'b0;
        next_mem.addr = sfw_pkg::ws_addr(next_wp, sfw_pkg::R_OLD_PC);
      end
      SFW_RET_ST: begin
        next_mem.we = 1'b0;
        next_mem.addr = sfw_pkg::ws_addr(next_wp, sfw_pkg::R_OLD_ST);
      end
    endcase
  end

  // ****************************************
  // Indexed address and serial I/O base
  // ****************************************
  always_comb begin
    next_idx_done = idx_req;
    next_idx_addr = idx_addr;
    if (idx_req) begin
      // Register zero selects plain symbolic addressing, no bias
      next_idx_addr = (idx_sel != 4'h0) ? idx_base + idx_value : idx_base;
    end
    next_io_base = r12_value[sfw_pkg::IO_BASE_HI:sfw_pkg::IO_BASE_LO];
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= SFW_IDLE;
      st <= sfw_pkg::ST_RESET;
      wp <= sfw_pkg::WP_RESET;
      hold_wp <= 16'h0000;
      hold_pc <= 16'h0000;
      hold_st <= 16'h0000;
      hold_link <= 16'h0000;
      hold_xop <= 1'b0;
      mem <= '0;
      result_word <= 16'h0000;
      pc_load <= 1'b0;
      pc_value <= 16'h0000;
      idx_addr <= 16'h0000;
      idx_done <= 1'b0;
      io_bit_base <= 12'h000;
    end else begin
      state <= next_state;
      st <= next_st;
      wp <= next_wp;
      hold_wp <= next_hold_wp;
      hold_pc <= next_hold_pc;
      hold_st <= next_hold_st;
      hold_link <= next_hold_link;
      hold_xop <= next_hold_xop;
      mem <= next_mem;
      result_word <= next_result;
      pc_load <= next_pc_load;
      pc_value <= next_pc_value;
      idx_addr <= next_idx_addr;
      idx_done <= next_idx_done;
      io_bit_base <= next_io_base;
    end
  end

endmodule

// File: verification/sfw_status_unit_checker.sv
`timescale 1ns/1ps
module sfw_status_unit_checker (
  input logic                     sys_clk,
  input logic                     reset,
  input sfw_pkg::sfw_cmd_type     cmd,
  input logic                     cmd_valid,
  input logic                     cmd_ready,
  input sfw_pkg::sfw_mem_req_type mem,
  input logic [15:0]              status_word,
  input logic [2:0]               ext_status_bits,
  input logic                     idx_req,
  input logic [3:0]               idx_sel,
  input logic [15:0]              idx_base,
  input logic [15:0]              idx_value,
  input logic [15:0]              idx_addr,
  input logic                     idx_done,
  input logic [15:0]              r12_value,
  input logic [11:0]              io_bit_base
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic        take;
  logic [15:0] frame_base;
  logic [15:0] woff;
  assign take = cmd_valid && cmd_ready;
  assign woff = (mem.req && mem.we) ? mem.addr - frame_base : 16'hFFFF;
  // Frame base held to follow the save sequence
  always_ff @(posedge sys_clk) begin
    if (take) begin
      frame_base <= cmd.aux;
    end
  end
  sequence s_xop_take;
    take && cmd.op == sfw_pkg::SFW_OP_XOP;
  endsequence
  sequence s_xop_saves;
    woff == 16'h001A ##1 woff == 16'h001C ##1 woff == 16'h001E ##1 woff == 16'h0016;
  endsequence
  sequence s_cmp_word;
    take && cmd.op == sfw_pkg::SFW_OP_CMP && !cmd.is_byte;
  endsequence
  AST_EXT_BITS: assert property (ext_status_bits == status_word[8:6])
    else $error("external status bits differ from status word");
  AST_IO_BASE: assert property (!$past(reset) |-> io_bit_base == $past(r12_value[12:1]))
    else $error("serial base address wrong");
  AST_IDX_PLAIN: assert property (idx_req && idx_sel == 4'h0 |=> idx_done && idx_addr == $past(idx_base))
    else $error("register zero added a bias");
  AST_IDX_BIAS: assert property (idx_req && idx_sel != 4'h0
    |=> idx_done && idx_addr == $past(idx_base) + $past(idx_value))
    else $error("indexed address wrong");
  AST_RESET_INT: assert property (take && cmd.op == sfw_pkg::SFW_OP_RESET_INT |=> status_word == 16'h0000)
    else $error("reset interrupt left status bits");
  AST_LOAD_MASK: assert property (take && cmd.op == sfw_pkg::SFW_OP_LOAD_MASK
    |=> status_word[3:0] == $past(cmd.src[3:0]) && status_word[15:4] == $past(status_word[15:4]))
    else $error("mask load wrong");
  AST_CMP_EQ: assert property (s_cmp_word |=> status_word[13] == ($past(cmd.src) == $past(cmd.dst)))
    else $error("equal flag wrong");
  AST_CMP_LGT: assert property (s_cmp_word |=> status_word[15] == ($past(cmd.src) > $past(cmd.dst)))
    else $error("unsigned greater flag wrong");
  AST_CMP_AGT: assert property (s_cmp_word
    |=> status_word[14] == ($signed($past(cmd.src)) > $signed($past(cmd.dst))))
    else $error("signed greater flag wrong");
  AST_MAX_NEG: assert property (take && (cmd.op == sfw_pkg::SFW_OP_ABS || cmd.op == sfw_pkg::SFW_OP_NEG)
    |=> status_word[11] == ($past(cmd.src) == sfw_pkg::MAX_NEG))
    else $error("overflow on maximum negative wrong");
  AST_XOP_SAVES: assert property (s_xop_take |=> s_xop_saves)
    else $error("trap frame saves out of order");
  AST_XOP_FLAG: assert property (s_xop_take
    |=> status_word[9] && status_word[8:4] == 5'h00 ##1 (!cmd_ready)[*3] ##1 cmd_ready)
    else $error("trap status or busy time wrong");
endmodule
bind sfw_status_unit sfw_status_unit_checker u_checker (.*);

// File: verification/sfw_ws_mem.sv
`timescale 1ns/1ps
module sfw_ws_mem (
  input  logic                     sys_clk,
  input  logic                     reset,
  input  logic                     slow,
  input  sfw_pkg::sfw_mem_req_type mem,
  output logic [15:0]              mem_rdata,
  output logic                     mem_rvalid
);
  logic [15:0] ram [0:255];
  logic [1:0]  wait_cnt;
  // Toggling data catches a late sample
  always_ff @(posedge sys_clk) begin
    mem_rvalid <= 1'b0;
    mem_rdata  <= ~mem_rdata;
    if (reset) begin
      wait_cnt  <= 2'h0;
      mem_rdata <= 16'hA5A5;
    end else if (mem.req && mem.we) begin
      ram[mem.addr[8:1]] <= mem.wdata;
    end else if (mem.req && !mem_rvalid) begin
      if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
        mem_rvalid <= 1'b1;
        mem_rdata  <= ram[mem.addr[8:1]];
        wait_cnt   <= 2'h0;
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule

// File: verification/sfw_status_unit_tb.sv
`timescale 1ns/1ps
module sfw_status_unit_tb;
  logic sys_clk, reset, cmd_valid, cmd_ready, mem_rvalid, pc_load, idx_req, idx_done, slow;
  sfw_pkg::sfw_cmd_type     cmd;
  sfw_pkg::sfw_mem_req_type mem;
  logic [15:0] mem_rdata, status_word, workspace_ptr, result_word, pc_value;
  logic [15:0] idx_base, idx_value, idx_addr, r12_value, r0v;
  logic [11:0] io_bit_base;
  logic [3:0]  idx_sel, lvl;
  logic [2:0]  ext_status_bits;
  logic        byt, ldi;
  int          miscompares, checks, n;
  logic [15:0] ca [5] = '{16'h8000, 16'h0001, 16'h1234, 16'h7FFF, 16'hFFFF};
  logic [15:0] cb [5] = '{16'h0001, 16'h8000, 16'h1234, 16'h8000, 16'hFFFE};

  sfw_status_unit dut (.*);
  sfw_ws_mem u_mem (.sys_clk(sys_clk), .reset(reset), .slow(slow), .mem(mem),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ****
  // Access tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic stuck(input string what);
    miscompares++;
    $display("mismatch at %0t: %s never came", $time, what);
    give_verdict();
  endtask
  task automatic wait_ready();
    for (n = 0; n == 0 || cmd_ready !== 1'b1; n++) begin
      if (n > 50) stuck("ready");
      @(posedge sys_clk);
      #1;
    end
  endtask
  // Returns just after the taking edge
  task automatic go(input sfw_pkg::sfw_op_type o, input logic [15:0] s = 16'h0000,
                    input logic [15:0] d = 16'h0000, input logic [15:0] a = 16'h0000,
                    input logic [3:0] c = 4'h0);
    wait_ready();
    cmd = '{op:o, is_byte:byt, src:s, dst:d, r0:r0v, aux:a, count:c, level:lvl, load_int:ldi};
    cmd_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
  endtask
  task automatic arith(input sfw_pkg::sfw_op_type o, input logic [15:0] s, input logic [15:0] d,
                       input logic [3:0] c, input logic [15:0] res, input logic [15:0] msk,
                       input logic [15:0] ex);
    go(o, s, d, 16'h0000, c);
    if (o != sfw_pkg::SFW_OP_DIV) chk(result_word, res, "result");
    chk(status_word & msk, ex, "flags");
  endtask
  task automatic index(input logic [3:0] sel, input logic [15:0] ex);
    @(posedge sys_clk);
    #1;
    idx_sel = sel;
    idx_req = 1'b1;
    @(posedge sys_clk);
    #1;
    idx_req = 1'b0;
    chk({15'h0000, idx_done}, 16'h0001, "index done");
    chk(idx_addr, ex, "index address");
  endtask

  // ****
  // Tests
  // ****
  initial begin
    {reset, cmd_valid, idx_req, slow, byt, ldi} = 6'h20;
    cmd = '0;
    {idx_sel, lvl} = 8'h00;
    {idx_base, idx_value, r12_value, r0v} = 64'h0;
    {miscompares, checks} = 0;
    repeat (20) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    chk(status_word, 16'h0000, "reset status");
    chk(workspace_ptr, 16'h0000, "reset pointer");
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      go(sfw_pkg::SFW_OP_CMP, ca[i], cb[i]);
      chk(status_word & 16'hE000, {ca[i] > cb[i], $signed(ca[i]) > $signed(cb[i]), ca[i] == cb[i], 13'h0}, "cmp");
    end
    byt = 1'b1;
    arith(sfw_pkg::SFW_OP_CMP, 16'h8300, 16'h0100, 4'h0, 16'h0100, 16'hE400, 16'h8400);
    byt = 1'b0;
    $display("test compare done");
    r0v = 16'h0002;
    arith(sfw_pkg::SFW_OP_ADD, 16'h0001, 16'h7FFF, 4'h0, 16'h8000, 16'h1800, 16'h0800);
    arith(sfw_pkg::SFW_OP_ADD, 16'h0001, 16'hFFFF, 4'h0, 16'h0000, 16'h1800, 16'h1000);
    arith(sfw_pkg::SFW_OP_SUB, 16'h0001, 16'h8000, 4'h0, 16'h7FFF, 16'h1800, 16'h1800);
    arith(sfw_pkg::SFW_OP_SUB, 16'h0002, 16'h0001, 4'h0, 16'hFFFF, 16'h1800, 16'h0000);
    arith(sfw_pkg::SFW_OP_MOVE, 16'h00FF, 16'h0000, 4'h0, 16'h00FF, 16'hE000, 16'hC000);
    arith(sfw_pkg::SFW_OP_NEG, 16'h8000, 16'h0000, 4'h0, 16'h8000, 16'h0800, 16'h0800);
    arith(sfw_pkg::SFW_OP_NEG, 16'h0005, 16'h0000, 4'h0, 16'hFFFB, 16'h0800, 16'h0000);
    arith(sfw_pkg::SFW_OP_ABS, 16'h8000, 16'h0000, 4'h0, 16'h8000, 16'h0800, 16'h0800);
    arith(sfw_pkg::SFW_OP_DIV, 16'h0005, 16'h0005, 4'h0, 16'h0000, 16'h0800, 16'h0800);
    arith(sfw_pkg::SFW_OP_DIV, 16'h0005, 16'h0004, 4'h0, 16'h0000, 16'h0800, 16'h0000);
    arith(sfw_pkg::SFW_OP_SLA, 16'h0000, 16'h4000, 4'h1, 16'h8000, 16'h1800, 16'h0800);
    arith(sfw_pkg::SFW_OP_SLA, 16'h0000, 16'h8001, 4'h1, 16'h0002, 16'h1800, 16'h1800);
    arith(sfw_pkg::SFW_OP_SRL, 16'h0000, 16'h0003, 4'h0, 16'h0000, 16'h1000, 16'h1000);
    arith(sfw_pkg::SFW_OP_SRA, 16'h0000, 16'h8000, 4'h4, 16'hF800, 16'h1000, 16'h0000);
    arith(sfw_pkg::SFW_OP_SRC, 16'h0000, 16'h0001, 4'h1, 16'h8000, 16'h1000, 16'h1000);
    $display("test arith done");
    go(sfw_pkg::SFW_OP_LOAD_ST, 16'hFFFF);
    go(sfw_pkg::SFW_OP_LOAD_MASK, 16'h0003);
    chk(status_word, 16'hFFF3, "mask load");
    chk({13'h0000, ext_status_bits}, 16'h0007, "external bits");
    go(sfw_pkg::SFW_OP_LOAD_WP, 16'h0000, 16'h0000, 16'h0100, 4'h0);
    chk(workspace_ptr, 16'h0100, "pointer load");
    go(sfw_pkg::SFW_OP_LOAD_ST, 16'h0DF5);
    $display("test status done");
    go(sfw_pkg::SFW_OP_XOP, 16'hABCD, 16'h1234, 16'h0200);
    chk(status_word, 16'h0E05, "trap status");
    chk(workspace_ptr, 16'h0200, "trap pointer");
    wait_ready();
    chk(u_mem.ram[8'h0D], 16'h0100, "saved pointer");
    chk(u_mem.ram[8'h0E], 16'h1234, "saved counter");
    chk(u_mem.ram[8'h0F], 16'h0DF5, "saved status");
    chk(u_mem.ram[8'h0B], 16'hABCD, "trap parameter");
    $display("test xop done");
    slow = 1'b1;
    go(sfw_pkg::SFW_OP_CTX_RET);
    for (n = 0; pc_load !== 1'b1; n++) begin
      if (n > 60) stuck("return");
      @(posedge sys_clk);
      #1;
    end
    chk(pc_value, 16'h1234, "return counter");
    chk(status_word, 16'h0DF5, "return status");
    chk(workspace_ptr, 16'h0100, "return pointer");
    slow = 1'b0;
    $display("test return done");
    lvl = 4'h5;
    go(sfw_pkg::SFW_OP_INTR, 16'h0000, 16'h2222, 16'h0300);
    chk(status_word, 16'h0C04, "interrupt status");
    wait_ready();
    chk(u_mem.ram[8'h8F], 16'h0DF5, "interrupt saved status");
    ldi = 1'b1;
    lvl = 4'h3;
    go(sfw_pkg::SFW_OP_INTR, 16'h0000, 16'h2222, 16'h0400);
    chk(status_word & 16'h000F, 16'h0004, "load interrupt mask");
    go(sfw_pkg::SFW_OP_BL, 16'h0000, 16'h0000, 16'h5555, 4'h0);
    wait_ready();
    chk(u_mem.ram[8'h0B], 16'h5555, "link register");
    go(sfw_pkg::SFW_OP_RESET_INT);
    chk(status_word, 16'h0000, "reset interrupt");
    $display("test interrupt done");
    {idx_base, idx_value} = {16'h1000, 16'h0020};
    index(4'h3, 16'h1020);
    index(4'h0, 16'h1000);
    r12_value = 16'hABCD;
    @(posedge sys_clk);
    #1;
    chk({4'h0, io_bit_base}, {4'h0, r12_value[12:1]}, "serial base");
    $display("test index done");
    give_verdict();
  end
endmodule
